// ### tpi_map.svh
// Constants for the touch panel serial target port
// Assumes inclusion by the package and tpi_target
`ifndef TPI_MAP_SVH
`define TPI_MAP_SVH
`define TPI_ADDR_HI      3'h3
`define TPI_ADDR_SEL_HI  7
`define TPI_ADDR_SEL_LO  4
`define TPI_BIT_LAST     3'h7
`define TPI_BIT_ZERO     3'h0
`define TPI_REG_ZERO     8'h00
`define TPI_BYTE_FF      8'hFF
`define TPI_PTR_ZERO     4'h0
`define TPI_PTR_ONE      4'h1
`define TPI_CFG_RESET    8'h00
`define TPI_ADDR_LSB     0
`endif

// ### tpi_pkg.sv
// Types for the touch panel serial target port
// Assumes tpi_map.svh is in the include path
`include "tpi_map.svh"
package tpi_pkg;
  typedef enum logic [2:0] {
    TPI_IDLE  = 3'b000,
    TPI_ADDR  = 3'b001,
    TPI_AACK  = 3'b011,
    TPI_WDATA = 3'b010,
    TPI_WACK  = 3'b110,
    TPI_RDATA = 3'b111,
    TPI_RACK  = 3'b101,
    TPI_SKIP  = 3'b100
  } tpi_state_e;
endpackage

// ### tpi_mem.sv
// Sixteen byte register store of the touch controller
// Assumes one clock; read data registered
`timescale 1ns/1ps
module tpi_mem
  import tpi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [3:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [3:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [0:15];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ### tpi_target.sv
// I2C target port of the touch panel controller
// Assumes clk at 100 MHz; scl and sda arrive asynchronously
`timescale 1ns/1ps
`include "tpi_map.svh"
// What this block does
// - Acts only as target; never drives scl, never makes start or stop.
// - Address is 011 plus address_select_config bits seven to four.
// - Stop ends a packet; repeated start ends it and begins another.
// - Any start, first or repeated, restarts decoding at address phase.
// - Drives an active low interrupt toward host on touch activity.
module tpi_target
  import tpi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       touch_rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  output logic            touch_panel_int_n,
  input  wire logic       touch_event,
  input  wire logic       touch_read_done,
  input  wire logic [7:0] address_select_config,
  output logic            packet_end,
  output logic            wr_strobe,
  output logic      [3:0] wr_index,
  output logic      [7:0] wr_data
);
  // ==========================================================
  // Input synchronisers
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [1:0] rst_sync_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic       cfg_sample_r;
  logic [3:0] addr_sel_r;

  always_ff @(posedge clk) begin
    scl_sync_r <= {scl_sync_r[0], scl_in};
    sda_sync_r <= {sda_sync_r[0], sda_in};
    rst_sync_r <= {rst_sync_r[0], touch_rst_n};
    scl_d_r    <= scl_sync_r[1];
    sda_d_r    <= sda_sync_r[1];
  end

  wire scl_s     = scl_sync_r[1];
  wire sda_s     = sda_sync_r[1];
  wire srst      = reset | ~rst_sync_r[1];
  wire scl_rise  = scl_s & ~scl_d_r;
  wire scl_fall  = ~scl_s & scl_d_r;
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ==========================================================
  // Address select configuration captured after reset release
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_sample_r <= 1'b1;
      addr_sel_r   <= `TPI_PTR_ZERO;
    end else if (cfg_sample_r) begin
      cfg_sample_r <= 1'b0;
      addr_sel_r   <=
        address_select_config[`TPI_ADDR_SEL_HI:`TPI_ADDR_SEL_LO];
    end
  end

  // ==========================================================
  // Protocol state
  tpi_state_e state_r, state_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic       rd_r, rd_nxt;
  logic       first_r, first_nxt;
  logic [3:0] ptr_r, ptr_nxt;
  logic       drive_r, drive_nxt;
  logic       bitval_r, bitval_nxt;
  logic       in_pkt_r;
  logic [7:0] mem_rdata;

  wire [6:0] my_addr   = {`TPI_ADDR_HI, addr_sel_r};
  wire       addr_hit  = shift_r[7:1] == my_addr;
  wire       byte_done = bit_r == `TPI_BIT_LAST;
  wire       do_write  = state_r == TPI_WACK && scl_fall && !drive_r &&
                         !first_r;
  wire       last_bit  = scl_rise && byte_done;

  always_comb begin
    state_nxt  = state_r;
    shift_nxt  = shift_r;
    bit_nxt    = bit_r;
    rd_nxt     = rd_r;
    first_nxt  = first_r;
    ptr_nxt    = ptr_r;
    drive_nxt  = drive_r;
    bitval_nxt = bitval_r;
    if (start_det) begin
      state_nxt = TPI_ADDR;
      bit_nxt   = `TPI_BIT_ZERO;
      drive_nxt = 1'b0;
    end else if (stop_det) begin
      state_nxt = TPI_IDLE;
      drive_nxt = 1'b0;
    end else begin
      case (state_r)
        TPI_ADDR, TPI_WDATA: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_s};
            bit_nxt   = bit_r + 3'h1;
          end
          if (scl_fall && bit_r == `TPI_BIT_ZERO && shift_r != `TPI_REG_ZERO
              && state_r == TPI_ADDR && first_r) begin
            state_nxt = TPI_ADDR;
          end
          if (last_bit) begin
            state_nxt = (state_r == TPI_ADDR) ? TPI_AACK : TPI_WACK;
          end
        end
        TPI_AACK: begin
          if (scl_fall && !drive_r) begin
            if (addr_hit) begin
              drive_nxt  = 1'b1;
              bitval_nxt = 1'b0;
              rd_nxt     = shift_r[`TPI_ADDR_LSB];
              first_nxt  = 1'b1;
            end else begin
              state_nxt = TPI_SKIP;
            end
          end else if (scl_fall && drive_r) begin
            bit_nxt = `TPI_BIT_ZERO;
            if (rd_r) begin
              state_nxt  = TPI_RDATA;
              shift_nxt  = mem_rdata;
              bitval_nxt = mem_rdata[7];
              ptr_nxt    = ptr_r + `TPI_PTR_ONE;
            end else begin
              state_nxt = TPI_WDATA;
              drive_nxt = 1'b0;
            end
          end
        end
        TPI_WACK: begin
          if (scl_fall && !drive_r) begin
            drive_nxt  = 1'b1;
            bitval_nxt = 1'b0;
            if (first_r) begin
              ptr_nxt = shift_r[3:0];
            end
          end else if (scl_fall && drive_r) begin
            drive_nxt = 1'b0;
            first_nxt = 1'b0;
            if (!first_r) begin
              ptr_nxt = ptr_r + `TPI_PTR_ONE;
            end
            bit_nxt   = `TPI_BIT_ZERO;
            state_nxt = TPI_WDATA;
          end
        end
        TPI_RDATA: begin
          if (scl_rise) begin
            bit_nxt = bit_r + 3'h1;
          end
          if (scl_fall) begin
            if (bit_r == `TPI_BIT_ZERO) begin
              drive_nxt = 1'b0;
              state_nxt = TPI_RACK;
            end else begin
              shift_nxt  = {shift_r[6:0], 1'b0};
              bitval_nxt = shift_r[6];
            end
          end
        end
        TPI_RACK: begin
          if (scl_rise) begin
            state_nxt = sda_s ? TPI_SKIP : TPI_RACK;
          end else if (scl_fall) begin
            bit_nxt    = `TPI_BIT_ZERO;
            state_nxt  = TPI_RDATA;
            drive_nxt  = 1'b1;
            shift_nxt  = mem_rdata;
            bitval_nxt = mem_rdata[7];
            ptr_nxt    = ptr_r + `TPI_PTR_ONE;
          end
        end
        default: begin
          drive_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r  <= TPI_IDLE;
      shift_r  <= `TPI_REG_ZERO;
      bit_r    <= `TPI_BIT_ZERO;
      rd_r     <= 1'b0;
      first_r  <= 1'b0;
      ptr_r    <= `TPI_PTR_ZERO;
      drive_r  <= 1'b0;
      bitval_r <= 1'b1;
    end else begin
      state_r  <= state_nxt;
      shift_r  <= shift_nxt;
      bit_r    <= bit_nxt;
      rd_r     <= rd_nxt;
      first_r  <= first_nxt;
      ptr_r    <= ptr_nxt;
      drive_r  <= drive_nxt;
      bitval_r <= bitval_nxt;
    end
  end

  // ==========================================================
  // Register store
  tpi_mem u_mem (
    .clk   (clk),
    .we    (do_write),
    .waddr (ptr_r),
    .wdata (shift_r),
    .raddr (ptr_r),
    .rdata (mem_rdata)
  );

  // ==========================================================
  // Outputs; scl is never driven, only sda low
  wire sda_low = drive_r & ~bitval_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      sda_out           <= 1'b1;
      sda_oe_n          <= 1'b1;
      touch_panel_int_n <= 1'b1;
      in_pkt_r          <= 1'b0;
      packet_end        <= 1'b0;
      wr_strobe         <= 1'b0;
      wr_index          <= `TPI_PTR_ZERO;
      wr_data           <= `TPI_REG_ZERO;
    end else begin
      sda_out  <= 1'b0;
      sda_oe_n <= ~sda_low;
      if (touch_event) begin
        touch_panel_int_n <= 1'b0;
      end else if (touch_read_done) begin
        touch_panel_int_n <= 1'b1;
      end
      packet_end <= in_pkt_r & (start_det | stop_det);
      if (start_det) begin
        in_pkt_r <= 1'b1;
      end else if (stop_det) begin
        in_pkt_r <= 1'b0;
      end
      wr_strobe <= do_write;
      if (do_write) begin
        wr_index <= ptr_r;
        wr_data  <= shift_r;
      end
    end
  end
endmodule

// ### tpi_target_asserts.sv
// Checks on the touch panel serial target port
// Assumes binding to tpi_target; one clock domain
`timescale 1ns/1ps
module tpi_target_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_oe_n,
  input wire logic touch_panel_int_n,
  input wire logic touch_event,
  input wire logic touch_read_done,
  input wire logic packet_end,
  input wire logic wr_strobe
);
  // ====
  // Properties
  default clocking cb @(posedge clk); endclocking
  sequence s_ack_hold;
    !sda_oe_n [*3];
  endsequence
  property p_drive_low;
    disable iff (reset) $changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("sda moved");
  property p_reset_quiet;
    disable iff (reset)
      $fell(reset) |-> sda_oe_n && touch_panel_int_n && !wr_strobe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("reset");
  property p_int_set;
    disable iff (reset) touch_event |=> !touch_panel_int_n;
  endproperty
  a_int_set: assert property (p_int_set) else $error("int set");
  property p_int_clear;
    disable iff (reset)
      touch_read_done && !touch_event |=> touch_panel_int_n;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("int clr");
  property p_pkt_end;
    disable iff (reset) packet_end |-> $past(scl_in, 4) ##1 !packet_end;
  endproperty
  a_pkt_end: assert property (p_pkt_end) else $error("pkt end");
  property p_wr_ack;
    disable iff (reset) wr_strobe |=> s_ack_hold;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("no ack");
  property p_wr_pulse;
    disable iff (reset) wr_strobe |=> !wr_strobe;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("strobe");
endmodule
bind tpi_target tpi_target_asserts i_chk (.clk(clk), .reset(reset),
  .scl_in(scl_in), .sda_oe_n(sda_oe_n),
  .touch_panel_int_n(touch_panel_int_n), .touch_event(touch_event),
  .touch_read_done(touch_read_done), .packet_end(packet_end),
  .wr_strobe(wr_strobe));

// ### tpi_host.sv
// Host model of the two-wire bus: start, stop, byte transfers
// Assumes a pull-up on sda; scl has a 125 ns period in frames
`timescale 1ns/1ps
module tpi_host (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  // ====
  // Bus conditions
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic start();
    #Q sda_drv = 1'b1;
    #(2*Q) scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
  endtask
  task automatic stop();
    #Q sda_drv = 1'b0;
    #(2*Q) scl = 1'b1;
    #Q sda_drv = 1'b1;
    #4700;
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic ta,
                         output logic [7:0] rx, output logic ra);
    logic [8:0] t;
    t = {tx, ta};
    for (int i = 8; i >= 0; i--) begin
      #Q sda_drv = t[i];
      #(2*Q) scl = 1'b1;
      #Q t[i] = sda;
      scl = 1'b0;
    end
    {rx, ra} = t;
  endtask
endmodule

// ### touch_panel_i2c_target_port_tb.sv
// Testbench of the touch panel serial target port
// Assumes tpi_target, tpi_host and the checker are compiled first
`timescale 1ns/1ps
module touch_panel_i2c_target_port_tb;
  `define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       touch_rst_n = 1'b1;
  logic       touch_event = 1'b0;
  logic       read_done = 1'b0;
  logic       scl, sda_drv, sda_out, sda_oe_n, int_n, ack;
  logic       packet_end, wr_strobe;
  logic [3:0] wr_index, exp_idx, idx;
  logic [7:0] sel, wr_data, rx, mem [16], bad [2];
  int         seed = 31, n_errors = 0, check_count = 0, n_pkt = 0, p0;
  wire        sda = sda_drv & (sda_oe_n | sda_out);
  always #5 clk = ~clk;
  tpi_host i_host (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  tpi_target i_dut (.clk(clk), .reset(reset), .touch_rst_n(touch_rst_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .touch_panel_int_n(int_n), .touch_event(touch_event),
    .touch_read_done(read_done), .address_select_config(sel),
    .packet_end(packet_end), .wr_strobe(wr_strobe), .wr_index(wr_index),
    .wr_data(wr_data));
  // ====
  // Monitors and tasks
  always @(posedge clk) begin
    if (packet_end === 1'b1) n_pkt++;
    if (wr_strobe === 1'b1) begin
      `CHK(wr_index, exp_idx)
      `CHK(wr_data, mem[exp_idx])
      exp_idx++;
    end
  end
  function automatic logic [7:0] addr_byte(input logic [3:0] s,
                                           input logic       rd);
    return {3'h3, s, rd};
  endfunction
  task automatic wr(input logic [7:0] d, input logic e);
    i_host.byte_io(d, 1'b1, rx, ack);
    `CHK(ack, e)
  endtask
  task automatic irq(input logic ev, input logic dn, input logic e);
    @(posedge clk);
    touch_event <= ev;
    read_done <= dn;
    @(posedge clk);
    touch_event <= 1'b0;
    read_done <= 1'b0;
    @(negedge clk);
    `CHK(int_n, e)
  endtask
  task automatic summarize();
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #900us;
    n_errors++;
    summarize();
  end
  // ====
  // Main sequence
  initial begin
    sel = 8'($random(seed));
    bad = '{{3'h3, ~sel[7:4], 1'b0}, {3'h7, sel[7:4], 1'b0}};
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (5) @(posedge clk);
    foreach (bad[k]) begin
      i_host.start();
      wr(bad[k], 1'b1);
      i_host.stop();
    end
    for (int k = 0; k < 4; k++) begin
      idx = k ? 4'($random(seed)) : 4'hF;
      p0 = n_pkt;
      i_host.start();
      wr(addr_byte(sel[7:4], 1'b0), 1'b0);
      wr({4'h0, idx}, 1'b0);
      exp_idx = idx;
      for (int j = 0; j < 2; j++) begin
        mem[idx + 4'(j)] = 8'($random(seed));
        wr(mem[idx + 4'(j)], 1'b0);
      end
      i_host.start();
      wr(addr_byte(sel[7:4], 1'b0), 1'b0);
      wr({4'h0, idx}, 1'b0);
      i_host.start();
      wr(addr_byte(sel[7:4], 1'b1), 1'b0);
      for (int j = 0; j < 2; j++) begin
        i_host.byte_io(8'hFF, 1'(j), rx, ack);
        `CHK(rx, mem[idx + 4'(j)])
      end
      i_host.stop();
      `CHK(n_pkt, p0 + 3)
    end
    irq(1'b1, 1'b0, 1'b0);
    irq(1'b1, 1'b1, 1'b0);
    irq(1'b0, 1'b1, 1'b1);
    irq(1'b1, 1'b0, 1'b0);
    touch_rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    touch_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK(int_n, 1'b1)
    summarize();
  end
endmodule
